// ==== rtl/ipc_pkg.sv ====
// Purpose: shared constants and types for the interrupt priority and context block
// Assumes: one clock, vector numbers 0..81, 13-byte cpu context
// Notes: context byte order is given by CTX_* indices
package ipc_pkg;
  localparam int unsigned NUM_VEC = 82;
  localparam int unsigned VNUM_W = 7;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned CTX_BYTES = 13;
  localparam int unsigned CTX_W = CTX_BYTES * 8;
  localparam int unsigned IDX_W = 4;
  // byte positions inside the saved context word
  localparam int unsigned CTX_STATUS = 0;
  localparam int unsigned CTX_WORKING_REGISTER = 1;
  localparam int unsigned CTX_BSR = 2;
  localparam int unsigned CTX_FSR0L = 3;
  localparam int unsigned CTX_FSR0H = 4;
  localparam int unsigned CTX_FSR1L = 5;
  localparam int unsigned CTX_FSR1H = 6;
  localparam int unsigned CTX_FSR2L = 7;
  localparam int unsigned CTX_FSR2H = 8;
  localparam int unsigned CTX_PRODL = 9;
  localparam int unsigned CTX_PRODH = 10;
  localparam int unsigned CTX_PCLATH = 11;
  localparam int unsigned CTX_PCLATU = 12;
  // context slots
  localparam logic SLOT_MAIN = 1'h0;
  localparam logic SLOT_LOW = 1'h1;
  // single-vector mode: low vector sits eight words above the base
  localparam logic [ADDR_W-1:0] LOW_VEC_OFS = 21'h000010;
  // state field codes
  localparam logic [1:0] STAT_MAIN = 2'h0;
  localparam logic [1:0] STAT_LOW = 2'h1;
  localparam logic [1:0] STAT_HIGH = 2'h2;
  localparam logic [1:0] STAT_HIGH_OVER_LOW = 2'h3;
  // reset values
  localparam logic [VNUM_W-1:0] VNUM_RST = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;

  typedef enum logic [1:0] {
    IPC_MAIN,
    IPC_LOW,
    IPC_HIGH,
    IPC_HIGH_OVER_LOW
  } ipc_exec_e;

  typedef logic [CTX_W-1:0] ipc_ctx_t;

  // slots with no source behind them never count as pending
  function automatic logic vec_used(input int unsigned i);
    return !(i == 36 || i == 58 || (i >= 62 && i <= 69) || (i >= 76 && i <= 79));
  endfunction
endpackage

// ==== rtl/ipc_ctx_if.sv ====
// Purpose: carrier between the controller and its context store
// Assumes: one clock domain
// Notes: read data are registered inside the store
`timescale 1ns/1ps
`default_nettype none
interface ipc_ctx_if;
  logic save_we;
  logic save_slot;
  ipc_pkg::ipc_ctx_t save_data;
  logic rd_slot;
  ipc_pkg::ipc_ctx_t rd_data;
  logic sw_we;
  logic sw_slot;
  logic [ipc_pkg::IDX_W-1:0] sw_idx;
  logic [7:0] sw_wdata;
  logic [7:0] sw_rdata;
  logic [1:0] valid;
  logic clr_valid;
  modport ctrl (output save_we, save_slot, save_data, rd_slot, sw_we, sw_slot, sw_idx,
    sw_wdata, clr_valid, input rd_data, sw_rdata, valid);
  modport store (input save_we, save_slot, save_data, rd_slot, sw_we, sw_slot, sw_idx,
    sw_wdata, clr_valid, output rd_data, sw_rdata, valid);
endinterface
`default_nettype wire

// ==== rtl/ipc_arbiter.sv ====
// Purpose: single-cycle resolution of pending requests per level
// Assumes: pending already masked by flags, enables and used slots
// Notes: with the level scheme off every source counts as high
`timescale 1ns/1ps
`default_nettype none
module ipc_arbiter (
  input wire logic [ipc_pkg::NUM_VEC-1:0] pending_i,
  input wire logic [ipc_pkg::NUM_VEC-1:0] level_i,
  input wire logic scheme_en_i,
  output logic hi_valid_o,
  output logic [ipc_pkg::VNUM_W-1:0] hi_num_o,
  output logic lo_valid_o,
  output logic [ipc_pkg::VNUM_W-1:0] lo_num_o
);
  logic is_hi;
  // [R27] combinational resolution
  always_comb begin
    is_hi = 1'h0;
    hi_valid_o = 1'h0;
    hi_num_o = ipc_pkg::VNUM_RST;
    lo_valid_o = 1'h0;
    lo_num_o = ipc_pkg::VNUM_RST;
    // [R2] [R3] scan downward, lowest number wins
    for (int i = ipc_pkg::NUM_VEC - 1; i >= 0; i--) begin
      // [R24] one level when scheme off
      is_hi = level_i[i] | ~scheme_en_i;
      if (pending_i[i] && is_hi) begin
        hi_valid_o = 1'h1;
        hi_num_o = ipc_pkg::VNUM_W'(i);
      end
      if (pending_i[i] && !is_hi) begin
        lo_valid_o = 1'h1;
        lo_num_o = ipc_pkg::VNUM_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ipc_shadow_mem.sv ====
// Purpose: two-slot context store, main and low-routine contexts
// Assumes: hardware save and software write never target the same byte usefully together
// Notes: hardware save wins over a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ipc_shadow_mem (
  input wire logic clk_i,
  input wire logic resetn_i,
  ipc_ctx_if.store bus
);
  typedef struct packed {
    ipc_pkg::ipc_ctx_t [1:0] slot;
    logic [1:0] valid;
    ipc_pkg::ipc_ctx_t rd;
    logic [7:0] sw_rd;
  } ipcm_state_s;
  ipcm_state_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    // [R22] software edits the saved bytes
    if (bus.sw_we && bus.sw_idx < ipc_pkg::IDX_W'(ipc_pkg::CTX_BYTES)) begin
      s_d.slot[bus.sw_slot][bus.sw_idx*8 +: 8] = bus.sw_wdata;
    end
    // [R17] independent main and low slots
    if (bus.save_we) begin
      s_d.slot[bus.save_slot] = bus.save_data;
      s_d.valid[bus.save_slot] = 1'h1;
    end
    if (bus.clr_valid) begin
      s_d.valid[bus.rd_slot] = 1'h0;
    end
    s_d.rd = s_q.slot[bus.rd_slot];
    // [R20] view select picks the slot
    s_d.sw_rd = (bus.sw_idx < ipc_pkg::IDX_W'(ipc_pkg::CTX_BYTES)) ?
      s_q.slot[bus.sw_slot][bus.sw_idx*8 +: 8] : 8'h00;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rd_data = s_q.rd;
  assign bus.sw_rdata = s_q.sw_rd;
  assign bus.valid = s_q.valid;
endmodule
`default_nettype wire

// ==== rtl/ipc_top.sv ====
// Purpose: interrupt arbitration, execution state tracking and context save/restore
// Assumes: boundary_i marks instruction boundaries; flags are cleared by their sources
// Notes: the cpu applies vector, stack and restore pulses; latency is the cpu's business
//
// Functional notes
// [R1] fixed vector number per source, 0..81
// [R2] equal level ties broken by vector order
// [R3] lower vector number wins within a level
// [R4] flag set means pending, all arbitrated
// [R5] save working register, then load vector
// [R6] flags cleared by software or sources
// [R7] main takes both; low routine only high
// [R8] execution state readable as status field
// [R9] global enables untouched; state machine tracks
// [R10] halt main, service, resume on return
// [R11] high serviced before pending low
// [R12] low waits until no high remains
// [R13] high preempts running low routine
// [R14] return resumes suspended low routine
// [R15] suspended low finishes despite low enable
// [R16] simultaneous high and low: high first
// [R17] two saved contexts: main and low
// [R18] push pc, save full cpu context
// [R19] same save both modes; one level
// [R20] select bit picks visible saved context
// [R21] exits restore the previous context
// [R22] software edits to saved context restored
// [R23] multi-vector address is base plus 2*number
// [R24] level scheme only when enable set
// [R25] return operand chooses context restore
// [R26] reset: main state, nothing saved, main view; the view follows context_view_select_i, which reset does not touch
// [R27] arbitration completes in one cycle
`timescale 1ns/1ps
`default_nettype none
module ipc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ipc_pkg::NUM_VEC-1:0] request_flag_regs_i,
  input wire logic [ipc_pkg::NUM_VEC-1:0] source_enable_i,
  input wire logic [ipc_pkg::NUM_VEC-1:0] source_level_select_regs_i,
  input wire logic global_high_enable_i,
  input wire logic global_low_enable_i,
  input wire logic level_scheme_enable_i,
  input wire logic vector_table_mode_i,
  input wire logic [ipc_pkg::ADDR_W-1:0] vector_table_base_i,
  input wire logic context_view_select_i,
  input wire logic boundary_i,
  input wire logic return_from_irq_op_i,
  input wire logic return_restore_i,
  input wire logic [ipc_pkg::CTX_W-1:0] cpu_ctx_i,
  input wire logic shadow_wr_i,
  input wire logic [ipc_pkg::IDX_W-1:0] shadow_idx_i,
  input wire logic [7:0] shadow_wdata_i,
  output logic vector_o,
  output logic [ipc_pkg::VNUM_W-1:0] vector_num_o,
  output logic [ipc_pkg::ADDR_W-1:0] vector_addr_o,
  output logic [7:0] working_register_o,
  output logic pc_push_o,
  output logic pc_pop_o,
  output logic restore_o,
  output logic [ipc_pkg::CTX_W-1:0] restore_ctx_o,
  output logic [1:0] irq_control_two_state_o,
  output logic [1:0] ctx_valid_o,
  output logic [7:0] shadow_rdata_o
);
  typedef struct packed {
    ipc_pkg::ipc_exec_e st;
    logic vec;
    logic [ipc_pkg::VNUM_W-1:0] vnum;
    logic [ipc_pkg::ADDR_W-1:0] vaddr;
    logic push;
    logic pop;
    logic rest;
    logic [1:0] stat;
  } ipc_state_s;
  ipc_state_s s_q, s_d;

  ipc_ctx_if cbus ();

  logic [ipc_pkg::NUM_VEC-1:0] pending;
  logic hi_valid;
  logic lo_valid;
  logic [ipc_pkg::VNUM_W-1:0] hi_num;
  logic [ipc_pkg::VNUM_W-1:0] lo_num;
  logic take_hi;
  logic take_lo;
  logic take;
  logic [ipc_pkg::VNUM_W-1:0] take_num;
  logic ret;
  logic rd_slot;

  // [R1] unused slots never pend
  genvar g;
  generate
    for (g = 0; g < ipc_pkg::NUM_VEC; g++) begin : g_pend
      // [R4] flag and enable form pending
      // [R6] flags read only, never cleared here
      assign pending[g] = request_flag_regs_i[g] & source_enable_i[g] &
        ipc_pkg::vec_used(g);
    end
  endgenerate

  ipc_arbiter u_arb (
    .pending_i(pending),
    .level_i(source_level_select_regs_i),
    .scheme_en_i(level_scheme_enable_i),
    .hi_valid_o(hi_valid),
    .hi_num_o(hi_num),
    .lo_valid_o(lo_valid),
    .lo_num_o(lo_num)
  );

  ipc_shadow_mem u_mem (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bus(cbus)
  );

  // a return outside main in the same cycle as a boundary goes first, so no vectoring then
  assign ret = return_from_irq_op_i && (s_q.st != ipc_pkg::IPC_MAIN);

  // acceptance per state; enables only gate, never get modified
  always_comb begin
    take_hi = 1'h0;
    take_lo = 1'h0;
    if (boundary_i && !ret) begin
      unique case (s_q.st)
        ipc_pkg::IPC_MAIN: begin
          // [R7] [R9] main accepts either level
          // [R11] [R16] high chosen over low
          take_hi = hi_valid & global_high_enable_i;
          // [R12] low only with no high pending
          take_lo = !hi_valid & lo_valid & global_high_enable_i & global_low_enable_i &
            level_scheme_enable_i;
        end
        ipc_pkg::IPC_LOW: begin
          // [R13] high preempts low routine
          take_hi = hi_valid & global_high_enable_i & level_scheme_enable_i;
        end
        ipc_pkg::IPC_HIGH,
        ipc_pkg::IPC_HIGH_OVER_LOW: begin
          take_hi = 1'h0;
        end
      endcase
    end
  end

  assign take = take_hi | take_lo;
  assign take_num = take_hi ? hi_num : lo_num;

  // slot to restore on a return; it is read one cycle ahead of restore_o
  always_comb begin
    rd_slot = ipc_pkg::SLOT_MAIN;
    if (s_q.st == ipc_pkg::IPC_HIGH_OVER_LOW) begin
      rd_slot = ipc_pkg::SLOT_LOW;
    end
  end

  always_comb begin
    cbus.rd_slot = rd_slot;
    // [R5] [R18] context captured at vectoring
    cbus.save_we = take;
    // [R17] [R19] low slot only under preemption
    cbus.save_slot = (s_q.st == ipc_pkg::IPC_LOW) ? ipc_pkg::SLOT_LOW : ipc_pkg::SLOT_MAIN;
    cbus.save_data = cpu_ctx_i;
    // the slot is consumed by the return, whether restored or not
    cbus.clr_valid = ret;
    // [R20] [R22] software view and edit
    cbus.sw_we = shadow_wr_i;
    cbus.sw_slot = context_view_select_i;
    cbus.sw_idx = shadow_idx_i;
    cbus.sw_wdata = shadow_wdata_i;
  end

  always_comb begin
    s_d = s_q;
    s_d.vec = 1'h0;
    s_d.push = 1'h0;
    s_d.pop = 1'h0;
    s_d.rest = 1'h0;
    if (ret) begin
      s_d.pop = 1'h1;
      // [R25] operand selects context restore
      s_d.rest = return_restore_i;
      unique case (s_q.st)
        // [R14] [R15] back to suspended low
        // [R21] low context comes back
        ipc_pkg::IPC_HIGH_OVER_LOW: s_d.st = ipc_pkg::IPC_LOW;
        // [R10] resume main on return
        ipc_pkg::IPC_HIGH: s_d.st = ipc_pkg::IPC_MAIN;
        ipc_pkg::IPC_LOW: s_d.st = ipc_pkg::IPC_MAIN;
        ipc_pkg::IPC_MAIN: s_d.st = ipc_pkg::IPC_MAIN;
      endcase
    end else if (take) begin
      // [R18] pc goes onto the return stack
      s_d.push = 1'h1;
      s_d.vec = 1'h1;
      // [R5] vector number into working register
      s_d.vnum = take_num;
      // [R23] base plus twice the number
      if (vector_table_mode_i) begin
        s_d.vaddr = ipc_pkg::ADDR_W'(vector_table_base_i + {take_num, 1'h0});
      end else if (take_lo) begin
        s_d.vaddr = ipc_pkg::ADDR_W'(vector_table_base_i + ipc_pkg::LOW_VEC_OFS);
      end else begin
        s_d.vaddr = vector_table_base_i;
      end
      if (take_lo) begin
        s_d.st = ipc_pkg::IPC_LOW;
      end else if (s_q.st == ipc_pkg::IPC_LOW) begin
        s_d.st = ipc_pkg::IPC_HIGH_OVER_LOW;
      end else begin
        s_d.st = ipc_pkg::IPC_HIGH;
      end
    end
    // [R8] state field follows the machine
    unique case (s_d.st)
      ipc_pkg::IPC_MAIN: s_d.stat = ipc_pkg::STAT_MAIN;
      ipc_pkg::IPC_LOW: s_d.stat = ipc_pkg::STAT_LOW;
      ipc_pkg::IPC_HIGH: s_d.stat = ipc_pkg::STAT_HIGH;
      ipc_pkg::IPC_HIGH_OVER_LOW: s_d.stat = ipc_pkg::STAT_HIGH_OVER_LOW;
    endcase
  end

  // [R26] reset into main, no vector pending
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q.st <= ipc_pkg::IPC_MAIN;
      s_q.vec <= 1'h0;
      s_q.vnum <= ipc_pkg::VNUM_RST;
      s_q.vaddr <= ipc_pkg::ADDR_RST;
      s_q.push <= 1'h0;
      s_q.pop <= 1'h0;
      s_q.rest <= 1'h0;
      s_q.stat <= ipc_pkg::STAT_MAIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign vector_o = s_q.vec;
  assign vector_num_o = s_q.vnum;
  assign vector_addr_o = s_q.vaddr;
  assign working_register_o = {1'h0, s_q.vnum};
  assign pc_push_o = s_q.push;
  assign pc_pop_o = s_q.pop;
  assign restore_o = s_q.rest;
  // [R21] [R22] restored bytes come from the store register
  assign restore_ctx_o = cbus.rd_data;
  assign irq_control_two_state_o = s_q.stat;
  assign ctx_valid_o = cbus.valid;
  assign shadow_rdata_o = cbus.sw_rdata;
endmodule
`default_nettype wire

// ==== dv/ipc_monitor.sv ====
// Purpose: port-level checks on ipc_top
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module ipc_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic boundary_i,
  input wire logic return_from_irq_op_i,
  input wire logic return_restore_i,
  input wire logic vector_o,
  input wire logic [6:0] vector_num_o,
  input wire logic [7:0] working_register_o,
  input wire logic pc_push_o,
  input wire logic pc_pop_o,
  input wire logic restore_o,
  input wire logic [1:0] irq_control_two_state_o,
  input wire logic [1:0] ctx_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] st;
  logic ret;
  assign st = irq_control_two_state_o;
  // a return in main is ignored, so only count it outside main
  assign ret = return_from_irq_op_i && st != 2'h0;
  a_push_with_vec: assert property (pc_push_o == vector_o)
    else $error("pc push and vector differ");
  a_working_register_is_num: assert property (vector_o |-> working_register_o == {1'h0, vector_num_o})
    else $error("working register not vector number");
  a_vec_at_boundary: assert property (vector_o |-> $past(boundary_i))
    else $error("vector without boundary");
  a_high_blocks_all: assert property (vector_o |-> $past(st) < 2'h2)
    else $error("accept inside high routine");
  a_pop_on_return: assert property (ret |=> pc_pop_o)
    else $error("return not popped");
  a_restore_follows_op: assert property (ret |=> restore_o == $past(return_restore_i))
    else $error("restore pulse differs from operand");
  a_resume_low: assert property (ret && st == 2'h3 |=> st == 2'h1)
    else $error("low routine not resumed");
  a_exit_to_main: assert property (ret && st != 2'h3 |=> st == 2'h0)
    else $error("return did not reach main");
  a_low_ctx_held: assert property (st == 2'h3 |-> ctx_valid_o == 2'h3)
    else $error("nested state without both contexts");
  c_low_entry: cover property (vector_o && st == 2'h1);
  c_nested: cover property (st == 2'h3);
  c_restore: cover property (restore_o);
endmodule
`default_nettype wire

// ==== dv/ipc_cpu_model.sv ====
// Purpose: cpu core stand-in for ipc_top
// Assumes: drives only at falling edges
// Notes: every third slot has no boundary, so acceptance can wait
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
  input wire logic clk_i,
  input wire logic vector_i,
  input wire logic restore_i,
  input wire logic [103:0] restore_ctx_i,
  output logic boundary_o,
  output logic ret_o,
  output logic ret_op_o,
  output logic [103:0] ctx_o
);
  logic [1:0] cyc = 2'h0;
  logic bnd_q = 1'h1;
  logic ret_q = 1'h0;
  logic op_q = 1'h0;
  logic [103:0] ctx_q = {13{8'h5A}};
  // one driver per output: the register behind it
  assign boundary_o = bnd_q;
  assign ret_o = ret_q;
  assign ret_op_o = op_q;
  assign ctx_o = ctx_q;
  always @(negedge clk_i) begin
    cyc <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
    bnd_q <= (cyc != 2'h2);
    if (restore_i) begin
      ctx_q <= restore_ctx_i;
    end else if (vector_i) begin
      ctx_q <= ~ctx_q;
    end
  end
  // operand line shows the inverse once released, never a stale value
  task automatic ret(input logic op);
    @(negedge clk_i);
    ret_q = 1'h1;
    op_q = op;
    @(negedge clk_i);
    ret_q = 1'h0;
    op_q = ~op;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for ipc_top
// Assumes: inputs change at falling edges
// Notes: cpu side comes from ipc_cpu_model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [81:0] fl = '0;
  logic [81:0] en = '1;
  logic [81:0] lv = '1;
  logic gh = 1'h1;
  logic gl = 1'h1;
  logic sch = 1'h1;
  logic mode = 1'h1;
  logic view = 1'h0;
  logic swr = 1'h0;
  logic [3:0] sidx = 4'h1;
  logic [7:0] swd = 8'h3C;
  logic [20:0] base = 21'h000100;
  logic bnd, ret, rop, vec, push, pop, rsto;
  logic [6:0] num;
  logic [20:0] addr;
  logic [7:0] working_register, srd;
  logic [103:0] ctx, rctx, exp, keep;
  logic [1:0] st, cv;
  int fails = 0;
  int n_checks = 0;
  ipc_top ipc_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .request_flag_regs_i(fl),
    .source_enable_i(en), .source_level_select_regs_i(lv), .global_high_enable_i(gh),
    .global_low_enable_i(gl), .level_scheme_enable_i(sch), .vector_table_mode_i(mode),
    .vector_table_base_i(base), .context_view_select_i(view), .boundary_i(bnd),
    .return_from_irq_op_i(ret), .return_restore_i(rop), .cpu_ctx_i(ctx),
    .shadow_wr_i(swr), .shadow_idx_i(sidx), .shadow_wdata_i(swd), .vector_o(vec),
    .vector_num_o(num), .vector_addr_o(addr), .working_register_o(working_register),
    .pc_push_o(push), .pc_pop_o(pop), .restore_o(rsto), .restore_ctx_o(rctx),
    .irq_control_two_state_o(st), .ctx_valid_o(cv), .shadow_rdata_o(srd));
  ipc_cpu_model ipc_cpu_model_i (.clk_i(clk_i), .vector_i(vec), .restore_i(rsto),
    .restore_ctx_i(rctx), .boundary_o(bnd), .ret_o(ret), .ret_op_o(rop), .ctx_o(ctx));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [103:0] got, input logic [103:0] want);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_vec(input logic [6:0] n, input logic [1:0] s);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (vec !== 1'h1 && k < 8);
    chk(vec, 1'h1);
    chk(num, n);
    chk(working_register, {1'h0, n});
    chk(st, s);
  endtask
  task automatic do_ret(input logic op, input logic [1:0] s);
    ipc_cpu_model_i.ret(op);
    chk({pop, rsto, st}, {1'h1, op, s});
  endtask
  task automatic t_reset();
    chk({st, cv, vec, push, pop, rsto}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_order();
    logic [6:0] a [2] = '{7'h51, 7'h00};
    logic [6:0] b [2] = '{7'h03, 7'h51};
    logic [6:0] w [2] = '{7'h03, 7'h00};
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i);
      exp = ctx;
      fl[a[i]] = 1'h1;
      fl[b[i]] = 1'h1;
      wait_vec(w[i], 2'h2);
      chk(addr, base + 21'(2 * w[i]));
      chk(cv, 2'h1);
      fl = '0;
      do_ret(1'h1, 2'h0);
      chk(rctx, exp);
    end
    $display("test order done");
  endtask
  task automatic t_levels();
    @(negedge clk_i);
    keep = ctx;
    lv[10] = 1'h0;
    fl[10] = 1'h1;
    fl[20] = 1'h1;
    fl[30] = 1'h1;
    wait_vec(7'h14, 2'h2);
    fl[20] = 1'h0;
    do_ret(1'h1, 2'h0);
    wait_vec(7'h1E, 2'h2);
    fl[30] = 1'h0;
    do_ret(1'h1, 2'h0);
    wait_vec(7'h0A, 2'h1);
    repeat (4) @(negedge clk_i);
    chk(st, 2'h1);
    chk(srd, keep[15:8]);
    exp = ctx;
    gl = 1'h0;
    fl[7] = 1'h1;
    wait_vec(7'h07, 2'h3);
    chk(cv, 2'h3);
    fl = '0;
    view = 1'h1;
    swr = 1'h1;
    @(negedge clk_i);
    swr = 1'h0;
    @(negedge clk_i);
    chk(srd, 8'h3C);
    exp[15:8] = 8'h3C;
    do_ret(1'h1, 2'h1);
    chk(rctx, exp);
    do_ret(1'h0, 2'h0);
    chk(cv, 2'h0);
    gl = 1'h1;
    view = 1'h0;
    $display("test levels done");
  endtask
  task automatic t_one_level();
    sch = 1'h0;
    mode = 1'h0;
    fl[36] = 1'h1;
    repeat (4) @(negedge clk_i);
    chk(st, 2'h0);
    en[39] = 1'h0;
    lv[40] = 1'h0;
    fl[39] = 1'h1;
    fl[40] = 1'h1;
    wait_vec(7'h28, 2'h2);
    chk(addr, base);
    chk(cv, 2'h1);
    fl = '0;
    do_ret(1'h1, 2'h0);
    // single-vector mode: low entry sits at the fixed offset
    sch = 1'h1;
    fl[40] = 1'h1;
    wait_vec(7'h28, 2'h1);
    chk(addr, base + ipc_pkg::LOW_VEC_OFS);
    fl = '0;
    do_ret(1'h1, 2'h0);
    // a return seen in main must change nothing
    ipc_cpu_model_i.ret(1'h1);
    chk({pop, rsto, st, cv}, 6'h00);
    $display("test one level done");
  endtask
  task automatic t_mid_reset();
    fl[5] = 1'h1;
    wait_vec(7'h05, 2'h2);
    chk(cv, 2'h1);
    // reset lands while a high routine is open
    resetn_i = 1'h0;
    @(negedge clk_i);
    chk({st, cv, vec, push, pop, rsto}, 8'h00);
    fl = '0;
    resetn_i = 1'h1;
    repeat (2) @(negedge clk_i);
    chk(srd, 8'h00);
    chk(st, 2'h0);
    $display("test mid reset done");
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    resetn_i = 1'h1;
    t_reset();
    t_order();
    t_levels();
    t_one_level();
    t_mid_reset();
    close_out();
  end
  // tests need about 50 cycles; allow about twenty times that
  initial begin
    #5000;
    fails++;
    close_out();
  end
endmodule
bind ipc_top ipc_monitor ipc_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .boundary_i(boundary_i), .return_from_irq_op_i(return_from_irq_op_i),
  .return_restore_i(return_restore_i), .vector_o(vector_o), .vector_num_o(vector_num_o),
  .working_register_o(working_register_o), .pc_push_o(pc_push_o), .pc_pop_o(pc_pop_o),
  .restore_o(restore_o), .irq_control_two_state_o(irq_control_two_state_o),
  .ctx_valid_o(ctx_valid_o));
`default_nettype wire
